// ===== logic/pif_params.svh
// Purpose: Offsets, field positions and reset values of the peripheral flag block
// Assumes: Byte-wide registers on a plain address/strobe port
// Notes: Definitions only
`ifndef PIF_PARAMS_SVH
`define PIF_PARAMS_SVH

`define PIF_ADDR_W 9
// Flag register and the four mirrors of the control register
`define PIF_OFF_FLAGS 9'h00C
`define PIF_OFF_CTRL_B0 9'h00B
`define PIF_OFF_CTRL_B1 9'h08B
`define PIF_OFF_CTRL_B2 9'h10B
`define PIF_OFF_CTRL_B3 9'h18B
// Enable register, the interrupt mask/status and the config register of this block
`define PIF_OFF_ENABLE 9'h08C
`define PIF_OFF_EVT_STATUS 9'h1F0
`define PIF_OFF_EVT_MASK 9'h1F1
`define PIF_OFF_CONFIG 9'h1F2
// Flag bit positions
`define PIF_BIT_PAR 7
`define PIF_BIT_CONV 6
`define PIF_BIT_RX 5
`define PIF_BIT_TX 4
`define PIF_BIT_SYNC 3
`define PIF_BIT_CAPCMP 2
`define PIF_BIT_TMRB 1
`define PIF_BIT_TMRA 0
// Control register bit positions
`define PIF_BIT_GIE 7
`define PIF_BIT_PERIPHERAL_IRQ_ENABLE 6
// Bits of the flag register that software may write
`define PIF_SW_MASK 8'hCF
// Reset values
`define PIF_RST_FLAGS 8'h00
`define PIF_RST_CTRL 8'h00
`define PIF_RST_ENABLE 8'h00
`define PIF_RST_MASK 8'h00
`define PIF_RST_CONFIG 8'h00

`endif

// ===== logic/pif_pkg.sv
// Purpose: Types shared by the peripheral flag block
// Assumes: Nothing
// Notes: Constants live in pif_params.svh
package pif_pkg;
	typedef enum logic [1:0] {PIF_CCP_OFF, PIF_CCP_CAPTURE, PIF_CCP_COMPARE, PIF_CCP_PWM} pif_ccp_mode_t;
	typedef enum logic [1:0] {PIF_RD_IDLE, PIF_RD_VALID} pif_rd_state_t;
endpackage

// ===== logic/pif_sticky.sv
// Purpose: One row of sticky flags, set by hardware, cleared by software
// Assumes: Set and clear arrive on the same clock
// Notes: Set beats clear in the same cycle
`timescale 1ns/100ps
module pif_sticky #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);
	// Refuse a width the logic cannot serve
	if (W < 1) begin : g_bad_width
		$error("pif_sticky: width must be positive");
	end

	// ************************************************************
	// Per-bit sticky storage
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// Set wins so that an event never disappears under a clear
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					q[i] <= 1'b0;
				end else if (set[i]) begin
					q[i] <= 1'b1;
				end else if (clr[i]) begin
					q[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule

// ===== logic/pif_sync.sv
// Purpose: Three-stage synchroniser for the external parallel-port strobes
// Assumes: Input is asynchronous to CLK
// Notes: Edge counts only when stages two and three agree
`timescale 1ns/100ps
module pif_sync #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] rise
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] level;

	// Refuse a width the logic cannot serve
	if (W < 1) begin : g_bad_width
		$error("pif_sync: width must be positive");
	end

	// ************************************************************
	// Synchroniser chain; s1 is read by s2 alone
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			level <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			// Per-bit agreement, so one busy strobe cannot stall the other
			level <= (s2 & s3) | (level & (s2 | s3));
		end
	end

	// Rising edge of the agreed level, one cycle long
	assign rise = (s2 & s3) & ~level;
endmodule

// ===== logic/pif_top.sv
// Purpose: Peripheral interrupt flag collector with core interrupt request
// Assumes: Peripheral events are one-cycle pulses on CLK; pins are asynchronous
// Notes: Registers on a plain address/strobe port, read data one cycle later
// Contract
// - Flags set regardless of any enable
// - Bit 7 set on external port access
// - Bit 6 set on conversion complete
// - Bit 5 mirrors receive buffer full
// - Bit 4 mirrors transmit buffer empty
// - Bit 3 set per SPI/I2C slave transfer
// - I2C master events also set bit 3
// - Bit 2 capture/compare, unused in PWM
// - Bit 1 set on timer-b period match
// - Bit 0 set on timer-a overflow
// - Control register mirrored in every bank
`timescale 1ns/100ps
`include "pif_params.svh"
module pif_top #(
	parameter bit HAS_PAR_PORT = 1'b1
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [`PIF_ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic PAR_RD_N,
	input wire logic PAR_WR_N,
	input wire logic CONV_DONE,
	input wire logic RX_FULL,
	input wire logic TX_EMPTY,
	input wire logic SPI_DONE,
	input wire logic I2C_SLAVE_DONE,
	input wire logic I2C_MASTER_EVENT,
	input wire logic CAPTURE_EVENT,
	input wire logic COMPARE_MATCH,
	input wire logic TIMER_B_MATCH,
	input wire logic TIMER_A_OVERFLOW,
	input wire logic [2:0] CORE_IRQ_SET,
	output logic CORE_IRQ,
	output logic IRQ
);
	// ************************************************************
	// Storage
	// ************************************************************
	logic [7:0] irq_control;
	logic [7:0] enable;
	logic [7:0] evt_mask;
	logic [7:0] config_reg;
	logic [7:0] flags_sticky;
	logic [7:0] evt_status;
	logic [1:0] par_rise;
	logic rx_q;
	logic tx_q;
	pif_pkg::pif_ccp_mode_t ccp_mode;

	// ************************************************************
	// Address decode
	// ************************************************************
	wire sel_flags = ADDR == `PIF_OFF_FLAGS;
	wire sel_ctrl = (ADDR == `PIF_OFF_CTRL_B0) || (ADDR == `PIF_OFF_CTRL_B1) ||
		(ADDR == `PIF_OFF_CTRL_B2) || (ADDR == `PIF_OFF_CTRL_B3);
	wire sel_en = ADDR == `PIF_OFF_ENABLE;
	wire sel_stat = ADDR == `PIF_OFF_EVT_STATUS;
	wire sel_mask = ADDR == `PIF_OFF_EVT_MASK;
	wire sel_cfg = ADDR == `PIF_OFF_CONFIG;
	wire wr_flags = WR && sel_flags;

	// ************************************************************
	// Event sources
	// ************************************************************
	pif_sync #(.W(2)) u_par_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.d({~PAR_WR_N, ~PAR_RD_N}),
		.rise(par_rise)
	);

	// Capture/compare mode chosen by software; PWM never flags
	assign ccp_mode = pif_pkg::pif_ccp_mode_t'(config_reg[1:0]);
	wire capcmp_evt = (ccp_mode == pif_pkg::PIF_CCP_CAPTURE && CAPTURE_EVENT) ||
		(ccp_mode == pif_pkg::PIF_CCP_COMPARE && COMPARE_MATCH);
	wire par_evt = HAS_PAR_PORT && (|par_rise);
	wire sync_evt = SPI_DONE || I2C_SLAVE_DONE || I2C_MASTER_EVENT;

	// Sets ignore every enable bit
	wire [7:0] flag_set = {par_evt, CONV_DONE, 1'b0, 1'b0, sync_evt, capcmp_evt,
		TIMER_B_MATCH, TIMER_A_OVERFLOW};
	// Software may only clear; writing a one leaves the flag as it was
	wire [7:0] flag_clr = wr_flags ? (~WDATA & `PIF_SW_MASK) : 8'h00;

	pif_sticky #(.W(8)) u_flags (
		.clk(CLK),
		.rst_n(RST_N),
		.set(flag_set),
		.clr(flag_clr),
		.q(flags_sticky)
	);

	// Buffer-state bits are live levels, registered once
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rx_q <= 1'b0;
			tx_q <= 1'b0;
		end else begin
			rx_q <= RX_FULL;
			tx_q <= TX_EMPTY;
		end
	end

	wire [7:0] flags = {flags_sticky[7:6], rx_q, tx_q, flags_sticky[3:0]};

	// ************************************************************
	// Control, enable, mask and config registers
	// ************************************************************
	// Low three control flags come from core-side sources and are sticky too
	wire [2:0] ctrl_flag_clr = (WR && sel_ctrl) ? ~WDATA[2:0] : 3'h0;
	wire [2:0] next_ctrl_flags = CORE_IRQ_SET | (irq_control[2:0] & ~ctrl_flag_clr);
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			irq_control <= `PIF_RST_CTRL;
			enable <= `PIF_RST_ENABLE;
			evt_mask <= `PIF_RST_MASK;
			config_reg <= `PIF_RST_CONFIG;
		end else begin
			irq_control[7:3] <= (WR && sel_ctrl) ? WDATA[7:3] : irq_control[7:3];
			irq_control[2:0] <= next_ctrl_flags;
			enable <= (WR && sel_en) ? WDATA : enable;
			evt_mask <= (WR && sel_mask) ? WDATA : evt_mask;
			config_reg <= (WR && sel_cfg) ? WDATA : config_reg;
		end
	end

	// ************************************************************
	// Block event status: sticky, write one to clear
	// ************************************************************
	wire [7:0] stat_clr = (WR && sel_stat) ? WDATA : 8'h00;
	wire [7:0] stat_set = flag_set;
	pif_sticky #(.W(8)) u_status (
		.clk(CLK),
		.rst_n(RST_N),
		.set(stat_set),
		.clr(stat_clr),
		.q(evt_status)
	);

	// ************************************************************
	// Interrupt request generation
	// ************************************************************
	wire periph_req = |(flags & enable);
	wire core_req_next = irq_control[`PIF_BIT_GIE] &&
		(((irq_control[`PIF_BIT_PERIPHERAL_IRQ_ENABLE]) && periph_req) ||
		(|(irq_control[5:3] & irq_control[2:0])));
	wire irq_next = |(evt_status & evt_mask);
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			CORE_IRQ <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			CORE_IRQ <= core_req_next;
			IRQ <= irq_next;
		end
	end

	// ************************************************************
	// Read port: data one cycle after the strobe, zero elsewhere
	// ************************************************************
	wire [7:0] rd_mux = sel_flags ? flags :
		sel_ctrl ? irq_control :
		sel_en ? enable :
		sel_stat ? evt_status :
		sel_mask ? evt_mask :
		sel_cfg ? config_reg : 8'h00;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			RDATA <= 8'h00;
		end else begin
			RDATA <= RD ? rd_mux : 8'h00;
		end
	end

	// ************************************************************
	// Checks: flags set by their events, whatever the enables
	// ************************************************************
	// Timer-a overflow lands on the next edge
	a_flag_set_wins: assert property (@(posedge CLK) disable iff (!RST_N)
		TIMER_A_OVERFLOW |=> flags_sticky[`PIF_BIT_TMRA])
		else $error("timer-a flag not set");
	// Timer-b match with every enable off still flags
	a_no_enable: assert property (@(posedge CLK) disable iff (!RST_N)
		(TIMER_B_MATCH && enable == 8'h00) |=> flags_sticky[`PIF_BIT_TMRB])
		else $error("flag gated by enable");
	// Period match flags whatever the global enable holds
	a_tmrb_sets: assert property (@(posedge CLK) disable iff (!RST_N)
		TIMER_B_MATCH |=> flags_sticky[`PIF_BIT_TMRB])
		else $error("timer-b flag not set");
	// Conversion complete flags bit six
	a_conv_sets: assert property (@(posedge CLK) disable iff (!RST_N)
		CONV_DONE |=> flags_sticky[`PIF_BIT_CONV])
		else $error("conversion flag not set");
	// Every synchronous serial source shares bit three
	a_sync_sets: assert property (@(posedge CLK) disable iff (!RST_N)
		(SPI_DONE || I2C_SLAVE_DONE || I2C_MASTER_EVENT) |=> flags_sticky[`PIF_BIT_SYNC])
		else $error("sync serial flag not set");
	// Master-side bus conditions flag as well
	a_master_sets: assert property (@(posedge CLK) disable iff (!RST_N)
		I2C_MASTER_EVENT |=> flags_sticky[`PIF_BIT_SYNC])
		else $error("master event not flagged");
	// Capture counts only in capture mode
	a_capture_sets: assert property (@(posedge CLK) disable iff (!RST_N)
		(ccp_mode == pif_pkg::PIF_CCP_CAPTURE && CAPTURE_EVENT) |=>
		flags_sticky[`PIF_BIT_CAPCMP])
		else $error("capture not flagged");
	// Compare match counts only in compare mode
	a_compare_sets: assert property (@(posedge CLK) disable iff (!RST_N)
		(ccp_mode == pif_pkg::PIF_CCP_COMPARE && COMPARE_MATCH) |=>
		flags_sticky[`PIF_BIT_CAPCMP])
		else $error("compare match not flagged");
	// The flag is unused in PWM mode, so it must not rise there
	a_pwm_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
		(ccp_mode == pif_pkg::PIF_CCP_PWM) |=> !$rose(flags_sticky[`PIF_BIT_CAPCMP]))
		else $error("capcmp set in pwm");
	// External port access flags the top bit
	a_par_access: assert property (@(posedge CLK) disable iff (!RST_N)
		par_evt |=> flags_sticky[`PIF_BIT_PAR])
		else $error("parallel flag not set");
	// Nothing but a port access may raise the top bit
	a_par_only: assert property (@(posedge CLK) disable iff (!RST_N)
		!par_evt |=> !$rose(flags_sticky[`PIF_BIT_PAR]))
		else $error("parallel flag rose unasked");

	// ************************************************************
	// Checks: sticky flags hold until software writes a zero
	// ************************************************************
	// Timer-a flag survives any cycle without a clearing write
	a_tmra_holds: assert property (@(posedge CLK) disable iff (!RST_N)
		(flags_sticky[`PIF_BIT_TMRA] && !(wr_flags && !WDATA[`PIF_BIT_TMRA])) |=>
		flags_sticky[`PIF_BIT_TMRA])
		else $error("timer-a flag dropped");
	// Timer-b flag survives any cycle without a clearing write
	a_tmrb_holds: assert property (@(posedge CLK) disable iff (!RST_N)
		(flags_sticky[`PIF_BIT_TMRB] && !(wr_flags && !WDATA[`PIF_BIT_TMRB])) |=>
		flags_sticky[`PIF_BIT_TMRB])
		else $error("timer-b flag dropped");
	// Conversion flag survives until written to zero
	a_conv_holds: assert property (@(posedge CLK) disable iff (!RST_N)
		(flags_sticky[`PIF_BIT_CONV] && !(wr_flags && !WDATA[`PIF_BIT_CONV])) |=>
		flags_sticky[`PIF_BIT_CONV])
		else $error("conversion flag dropped");
	// Port flag survives until software clears it
	a_par_holds: assert property (@(posedge CLK) disable iff (!RST_N)
		(flags_sticky[`PIF_BIT_PAR] && !(wr_flags && !WDATA[`PIF_BIT_PAR])) |=>
		flags_sticky[`PIF_BIT_PAR])
		else $error("parallel flag dropped");
	// Serial flag stays up for the routine to clear
	a_sync_holds: assert property (@(posedge CLK) disable iff (!RST_N)
		(flags_sticky[`PIF_BIT_SYNC] && !(wr_flags && !WDATA[`PIF_BIT_SYNC])) |=>
		flags_sticky[`PIF_BIT_SYNC])
		else $error("sync serial flag dropped");
	// Capture/compare flag stays up until cleared
	a_capcmp_holds: assert property (@(posedge CLK) disable iff (!RST_N)
		(flags_sticky[`PIF_BIT_CAPCMP] && !(wr_flags && !WDATA[`PIF_BIT_CAPCMP])) |=>
		flags_sticky[`PIF_BIT_CAPCMP])
		else $error("capcmp flag dropped");
	// A zero written with no event pending clears timer-a
	a_tmra_clears: assert property (@(posedge CLK) disable iff (!RST_N)
		(wr_flags && !WDATA[`PIF_BIT_TMRA] && !TIMER_A_OVERFLOW) |=>
		!flags_sticky[`PIF_BIT_TMRA])
		else $error("timer-a flag not cleared");
	// A write never sets a flag; only its event can
	a_no_sw_set: assert property (@(posedge CLK) disable iff (!RST_N)
		(!flags_sticky[`PIF_BIT_TMRB] && !TIMER_B_MATCH) |=> !flags_sticky[`PIF_BIT_TMRB])
		else $error("timer-b flag set without event");

	// ************************************************************
	// Checks: buffer-state bits follow their levels
	// ************************************************************
	// Receive bit shows the level one cycle late
	a_rx_level: assert property (@(posedge CLK) disable iff (!RST_N)
		1'b1 |=> flags[`PIF_BIT_RX] == $past(RX_FULL))
		else $error("receive flag wrong");
	// Transmit bit shows the level one cycle late
	a_tx_level: assert property (@(posedge CLK) disable iff (!RST_N)
		1'b1 |=> flags[`PIF_BIT_TX] == $past(TX_EMPTY))
		else $error("transmit flag wrong");

	// ************************************************************
	// Checks: control register and core request
	// ************************************************************
	// Every mirror reads the one control register
	a_mirror_read: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && sel_ctrl) |=> RDATA == $past(irq_control))
		else $error("control mirror read wrong");
	// Every mirror writes the one control register
	a_mirror_write: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && sel_ctrl) |=> irq_control[7:3] == $past(WDATA[7:3]))
		else $error("control mirror write lost");
	// Core-side pulse sets its control flag
	a_ctrl_flag_set: assert property (@(posedge CLK) disable iff (!RST_N)
		CORE_IRQ_SET[0] |=> irq_control[0])
		else $error("control flag not set");
	// Flag, its enable, peripheral and global enables raise the request
	a_core_request: assert property (@(posedge CLK) disable iff (!RST_N)
		(irq_control[`PIF_BIT_GIE] && irq_control[`PIF_BIT_PERIPHERAL_IRQ_ENABLE] && |(flags & enable)) |=>
		CORE_IRQ)
		else $error("core request missing");
	// Global enable off keeps the core quiet
	a_core_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
		!irq_control[`PIF_BIT_GIE] |=> !CORE_IRQ)
		else $error("core request without global enable");
	// Peripheral enable off blocks every peripheral flag
	a_periph_gate: assert property (@(posedge CLK) disable iff (!RST_N)
		(!irq_control[`PIF_BIT_PERIPHERAL_IRQ_ENABLE] && !(|(irq_control[5:3] & irq_control[2:0]))) |=>
		!CORE_IRQ)
		else $error("core request without peripheral enable");

	// ************************************************************
	// Checks: block status, interrupt line and read port
	// ************************************************************
	// Status follows the same set events as the flags
	a_status_sets: assert property (@(posedge CLK) disable iff (!RST_N)
		TIMER_A_OVERFLOW |=> evt_status[`PIF_BIT_TMRA])
		else $error("status bit not set");
	// Writing one clears a status bit when no event competes
	a_status_clear: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && sel_stat && WDATA[`PIF_BIT_TMRA] && !TIMER_A_OVERFLOW) |=>
		!evt_status[`PIF_BIT_TMRA])
		else $error("status bit not cleared");
	// An unmasked status bit raises the line
	a_irq_level: assert property (@(posedge CLK) disable iff (!RST_N)
		(|(evt_status & evt_mask)) |=> IRQ)
		else $error("interrupt line missing");
	// No unmasked status bit, no line
	a_irq_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
		!(|(evt_status & evt_mask)) |=> !IRQ)
		else $error("interrupt line without cause");
	// Read data stand only after a read strobe
	a_read_idle: assert property (@(posedge CLK) disable iff (!RST_N)
		!RD |=> RDATA == 8'h00)
		else $error("read data without strobe");
	// Enable register takes the written byte
	a_enable_write: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && sel_en) |=> enable == $past(WDATA))
		else $error("enable write lost");
endmodule

// ===== testbench/pif_periph_model.sv
// Purpose: Peripheral side of the flag block: event pulses, buffer levels, port strobes
// Assumes: Driven by the bench through its tasks, one call at a time
// Notes: Port strobes are held well past the pin synchroniser latency
`timescale 1ns/100ps
module pif_periph_model (
	input wire logic clk,
	output logic [7:0] ev,
	output logic rd_n,
	output logic wr_n,
	output logic rx_full,
	output logic tx_empty
);
	// Idle: no events, strobes released, transmit buffer loaded so bit 4 stays quiet
	initial begin
		ev = 8'h00;
		rd_n = 1'b1;
		wr_n = 1'b1;
		rx_full = 1'b0;
		tx_empty = 1'b0;
	end

	// One-cycle event pulse, launched just after an edge
	task automatic fire(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
	endtask

	// Serial buffer levels
	task automatic levels(input logic r, input logic t);
		@(posedge clk);
		rx_full <= r;
		tx_empty <= t;
	endtask

	// External master access; long hold since pins cross a three-flop chain
	task automatic access(input bit w);
		@(posedge clk);
		if (w)
			wr_n <= 1'b0;
		else
			rd_n <= 1'b0;
		repeat (6) @(posedge clk);
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
endmodule

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the peripheral flag collector
// Assumes: Events come from the peripheral model as one-cycle pulses
// Notes: Core-side control flags are pulsed through CORE_IRQ_SET
`timescale 1ns/100ps
`include "pif_params.svh"
module tb;
	logic CLK, RST_N, WR, RD, CORE_IRQ, IRQ;
	logic [`PIF_ADDR_W-1:0] ADDR;
	logic [7:0] WDATA, RDATA, ev;
	logic rd_n, wr_n, rx_full, tx_empty;
	logic [2:0] core_set;
	int bad_count = 0;
	int n_compared = 0;

	pif_periph_model u_per (.clk(CLK), .ev(ev), .rd_n(rd_n), .wr_n(wr_n),
		.rx_full(rx_full), .tx_empty(tx_empty));
	pif_top u_dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .PAR_RD_N(rd_n), .PAR_WR_N(wr_n), .CONV_DONE(ev[0]),
		.RX_FULL(rx_full), .TX_EMPTY(tx_empty), .SPI_DONE(ev[1]), .I2C_SLAVE_DONE(ev[2]),
		.I2C_MASTER_EVENT(ev[3]), .CAPTURE_EVENT(ev[4]), .COMPARE_MATCH(ev[5]),
		.TIMER_B_MATCH(ev[6]), .TIMER_A_OVERFLOW(ev[7]), .CORE_IRQ_SET(core_set),
		.CORE_IRQ(CORE_IRQ), .IRQ(IRQ));

	// 125 MHz core clock
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	// ****************************************
	// Bus and compare helpers
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick();
		@(posedge CLK);
		#1;
	endtask

	task automatic wr(input logic [`PIF_ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rdc(input logic [`PIF_ADDR_W-1:0] a, input logic [7:0] exp);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1;
		chk(RDATA, exp);
	endtask

	// Bounded wait on an interrupt output (sel 1 picks IRQ)
	task automatic wait_out(input bit sel, input logic exp);
		int n;
		for (n = 0; n < 8; n++) begin
			tick();
			if ((sel ? IRQ : CORE_IRQ) === exp)
				break;
		end
		chk({7'h00, sel ? IRQ : CORE_IRQ}, {7'h00, exp});
		if (n == 8)
			wrap_up();
	endtask

	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_mirror();
		logic [`PIF_ADDR_W-1:0] m[4] = '{`PIF_OFF_CTRL_B0, `PIF_OFF_CTRL_B1,
			`PIF_OFF_CTRL_B2, `PIF_OFF_CTRL_B3};
		rdc(`PIF_OFF_FLAGS, 8'h00);
		rdc(9'h000, 8'h00);
		wr(`PIF_OFF_CTRL_B2, 8'hC0);
		foreach (m[i])
			rdc(m[i], 8'hC0);
		wr(`PIF_OFF_CTRL_B3, 8'h00);
		rdc(`PIF_OFF_CTRL_B1, 8'h00);
	endtask

	// Every event with all enables off; capture and compare each in its own mode
	task automatic s_events();
		int ebit[8] = '{`PIF_BIT_CONV, `PIF_BIT_SYNC, `PIF_BIT_SYNC, `PIF_BIT_SYNC,
			`PIF_BIT_CAPCMP, `PIF_BIT_CAPCMP, `PIF_BIT_TMRB, `PIF_BIT_TMRA};
		for (int i = 0; i < 8; i++) begin
			wr(`PIF_OFF_CONFIG, (i == 5) ? 8'h02 : 8'h01);
			u_per.fire(i);
			rdc(`PIF_OFF_FLAGS, 8'h01 << ebit[i]);
			wr(`PIF_OFF_FLAGS, 8'h00);
			rdc(`PIF_OFF_FLAGS, 8'h00);
		end
		// PWM mode, then mode off: neither may flag
		for (int m = 0; m < 2; m++) begin
			wr(`PIF_OFF_CONFIG, m ? 8'h00 : 8'h03);
			u_per.fire(4);
			u_per.fire(5);
			rdc(`PIF_OFF_FLAGS, 8'h00);
		end
	endtask

	// Buffer levels show through and ignore writes
	task automatic s_levels();
		u_per.levels(1'b1, 1'b0);
		rdc(`PIF_OFF_FLAGS, 8'h20);
		wr(`PIF_OFF_FLAGS, 8'h00);
		rdc(`PIF_OFF_FLAGS, 8'h20);
		u_per.levels(1'b0, 1'b1);
		rdc(`PIF_OFF_FLAGS, 8'h10);
		wr(`PIF_OFF_FLAGS, 8'h00);
		rdc(`PIF_OFF_FLAGS, 8'h10);
		u_per.levels(1'b0, 1'b0);
		rdc(`PIF_OFF_FLAGS, 8'h00);
	endtask

	// Port read then port write; writing ones must not clear
	task automatic s_par();
		for (int w = 0; w < 2; w++) begin
			u_per.access(w[0]);
			wr(`PIF_OFF_FLAGS, 8'hFF);
			rdc(`PIF_OFF_FLAGS, 8'h80);
			wr(`PIF_OFF_FLAGS, 8'h00);
			rdc(`PIF_OFF_FLAGS, 8'h00);
		end
	endtask

	// Core request needs flag, its enable, peripheral and global enables
	task automatic s_core();
		wr(`PIF_OFF_FLAGS, 8'h00);
		wr(`PIF_OFF_EVT_STATUS, 8'hFF);
		wr(`PIF_OFF_EVT_MASK, 8'h01);
		wr(`PIF_OFF_ENABLE, 8'h01);
		wr(`PIF_OFF_CTRL_B0, 8'h40);
		wait_out(1'b1, 1'b0);
		u_per.fire(7);
		wait_out(1'b1, 1'b1);
		wait_out(1'b0, 1'b0);
		wr(`PIF_OFF_CTRL_B0, 8'hC0);
		wait_out(1'b0, 1'b1);
		wr(`PIF_OFF_ENABLE, 8'h00);
		wait_out(1'b0, 1'b0);
		wr(`PIF_OFF_EVT_STATUS, 8'h01);
		wait_out(1'b1, 1'b0);
	endtask

	// Core-side flag in control bit 0 with its enable in bit 3
	task automatic s_ctrl();
		wr(`PIF_OFF_CTRL_B1, 8'h88);
		@(posedge CLK);
		core_set <= 3'h1;
		@(posedge CLK);
		core_set <= 3'h0;
		wait_out(1'b0, 1'b1);
		rdc(`PIF_OFF_CTRL_B2, 8'h89);
		wr(`PIF_OFF_CTRL_B3, 8'h88);
		wait_out(1'b0, 1'b0);
		wr(`PIF_OFF_CTRL_B0, 8'h00);
	endtask

	// Main sequence
	initial begin
		RST_N = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = '0;
		WDATA = 8'h00;
		core_set = 3'h0;
		repeat (16) @(posedge CLK);
		RST_N <= 1'b1;
		s_mirror();
		s_events();
		s_levels();
		s_par();
		s_core();
		s_ctrl();
		wrap_up();
	end

	// Hang guard
	initial begin
		#400000;
		bad_count++;
		wrap_up();
	end
endmodule
